// ==== rtl/stp_phase_sequencer.sv ====
/*
 * Control logic of a unipolar two-phase stepper driver: step clock edge
 * detection, excitation sequencer, enable gating, latched protection
 * faults and an AHB-Lite register slave with interrupt.
 * Assumes every control pin and detector is asynchronous to hclk and that
 * hclk is much faster than the step clock.
 */
`timescale 1ns/1ps
module stp_phase_sequencer #(
    parameter int STEP_COUNT_W = 16
) (
    // Clock and chip reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [stp_pkg::STP_HADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [stp_pkg::STP_DATA_W-1:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [stp_pkg::STP_DATA_W-1:0] hrdata,
    // Control pins from the host
    input wire logic step_clock,
    input wire logic excitation_select,
    input wire logic step_edge_select,
    input wire logic rotation_direction,
    input wire logic system_reset_n,
    input wire logic enable,
    // Protection detectors
    input wire logic open_detect,
    input wire logic overcurrent_detect,
    input wire logic overheat_detect,
    // Phase drives
    output logic phase_one_true_drive,
    output logic phase_one_inverse_drive,
    output logic phase_two_true_drive,
    output logic phase_two_inverse_drive,
    // Fault reporting and interrupt
    output logic fault_flag_n,
    output logic [1:0] fault_kind_level,
    output logic irq
);
    import stp_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------
    logic [STP_PIN_W-1:0] pin_raw;
    logic [STP_PIN_W-1:0] pin_sync;
    logic s_clk;
    logic sel_half;
    logic sel_rise_only;
    logic sel_dir;
    logic s_sysrst;
    logic s_en;
    logic [2:0] s_fault;

    assign pin_raw[STP_PIN_CLK] = step_clock;
    assign pin_raw[STP_PIN_HALF] = excitation_select;
    assign pin_raw[STP_PIN_EDGE] = step_edge_select;
    assign pin_raw[STP_PIN_DIR] = rotation_direction;
    assign pin_raw[STP_PIN_SYSRST] = system_reset_n;
    assign pin_raw[STP_PIN_EN] = enable;
    assign pin_raw[STP_PIN_OPEN] = open_detect;
    assign pin_raw[STP_PIN_OC] = overcurrent_detect;
    assign pin_raw[STP_PIN_OT] = overheat_detect;

    stp_sync #(
        .W(STP_PIN_W)
    ) u_pin_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .d(pin_raw),
        .q(pin_sync)
    );

    // Mode pins are read only at an edge; the host keeps them still there.
    assign s_clk = pin_sync[STP_PIN_CLK];
    assign sel_half = pin_sync[STP_PIN_HALF];
    assign sel_rise_only = pin_sync[STP_PIN_EDGE];
    assign sel_dir = pin_sync[STP_PIN_DIR];
    assign s_sysrst = pin_sync[STP_PIN_SYSRST];
    assign s_en = pin_sync[STP_PIN_EN];
    assign s_fault = pin_sync[STP_PIN_OT:STP_PIN_OPEN];

    // ------------------------------------------------------------------
    // Step clock edges
    // ------------------------------------------------------------------
    logic clk_prev;
    logic clk_rise;
    logic clk_fall;
    logic active_edge;
    logic step_take;

    assign clk_rise = s_clk & ~clk_prev;
    assign clk_fall = ~s_clk & clk_prev;
    assign active_edge = clk_rise | (clk_fall & ~sel_rise_only);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_prev <= 1'b0;
        end else begin
            clk_prev <= s_clk;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------------
    stp_seq_t seq_state;
    stp_seq_t next_state;
    logic [2:0] position;
    logic [2:0] next_position;
    logic [2:0] step_size;
    logic [2:0] pos_fwd;
    logic [2:0] pos_rev;

    always_comb begin
        unique case (seq_state)
            SEQ_RESET: begin
                next_state = !s_sysrst ? SEQ_RESET :
                             (s_en ? SEQ_RUN : SEQ_HOLD);
            end
            SEQ_RUN: begin
                next_state = !s_sysrst ? SEQ_RESET :
                             (s_en ? SEQ_RUN : SEQ_HOLD);
            end
            SEQ_HOLD: begin
                next_state = !s_sysrst ? SEQ_RESET :
                             (s_en ? SEQ_RUN : SEQ_HOLD);
            end
            default: begin
                next_state = SEQ_RESET;
            end
        endcase
    end

    // Steps count only in RUN with both levels high; HOLD freezes position.
    assign step_take = active_edge & (seq_state == SEQ_RUN) &
                       s_sysrst & s_en;

    // An odd position left by half-step mode is first stepped to a pair.
    assign step_size = (sel_half | position[0]) ?
                       STP_STEP_HALF : STP_STEP_FULL;
    assign pos_fwd = 3'(position + step_size);
    assign pos_rev = 3'(position - step_size);

    assign next_position = !s_sysrst ? STP_POS_INIT :
                           (!step_take ? position :
                           (sel_dir ? pos_rev : pos_fwd));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq_state <= SEQ_RESET;
            position <= STP_POS_INIT;
        end else begin
            seq_state <= next_state;
            position <= next_position;
        end
    end

    // ------------------------------------------------------------------
    // Phase drive
    // ------------------------------------------------------------------
    logic drive_allow;
    logic drive_on;
    logic [3:0] pattern_now;
    logic [3:0] next_drive;
    logic [3:0] phase_drive;

    assign pattern_now = STP_PATTERN_TABLE[{position, 2'b00} +: 4];
    // System reset low turns the drives off at the next hclk edge after it is seen.
    assign drive_on = s_en & s_sysrst & drive_allow &
                      (seq_state != SEQ_RESET);
    assign next_drive = drive_on ? pattern_now : 4'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_drive <= 4'h0;
        end else begin
            phase_drive <= next_drive;
        end
    end

    assign phase_one_true_drive = phase_drive[0];
    assign phase_one_inverse_drive = phase_drive[1];
    assign phase_two_true_drive = phase_drive[2];
    assign phase_two_inverse_drive = phase_drive[3];

    // ------------------------------------------------------------------
    // Fault latch
    // ------------------------------------------------------------------
    logic [2:0] fault_latched;
    logic [2:0] next_faults;
    logic [2:0] fault_new;
    logic [1:0] next_kind;

    assign next_faults = !s_sysrst ? 3'h0 : (fault_latched | s_fault);
    assign fault_new = s_fault & ~fault_latched & {3{s_sysrst}};
    assign next_kind = next_faults[STP_FAULT_OT] ? STP_KIND_OVERHEAT :
                       next_faults[STP_FAULT_OC] ? STP_KIND_OVERCURRENT :
                       next_faults[STP_FAULT_OPEN] ? STP_KIND_OPEN :
                       STP_KIND_NONE;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_latched <= 3'h0;
            fault_flag_n <= 1'b1;
            fault_kind_level <= STP_KIND_NONE;
        end else begin
            fault_latched <= next_faults;
            fault_flag_n <= ~|next_faults;
            fault_kind_level <= next_kind;
        end
    end

    // ------------------------------------------------------------------
    // Step counter
    // ------------------------------------------------------------------
    logic [STEP_COUNT_W-1:0] step_count;
    logic [STEP_COUNT_W-1:0] next_count;

    assign next_count = !s_sysrst ? '0 :
                        (step_take ? STEP_COUNT_W'(step_count + 1'b1) :
                        step_count);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            step_count <= '0;
        end else begin
            step_count <= next_count;
        end
    end

    // ------------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------------
    // Only the low address byte is decoded, so the map aliases upward.
    logic bus_take;
    logic wr_pend;
    logic [STP_DEC_W-1:0] wr_addr;
    logic [STP_DEC_W-1:0] dec_addr;
    logic wr_control;
    logic wr_irq_status;
    logic wr_irq_mask;
    logic [STP_DATA_W-1:0] rd_value;
    logic [STP_DATA_W-1:0] status_word;
    logic [STP_IRQ_W-1:0] irq_status;
    logic [STP_IRQ_W-1:0] irq_mask;
    logic [STP_IRQ_W-1:0] irq_events;
    logic [STP_IRQ_W-1:0] irq_clear;

    assign bus_take = hsel & hready & htrans[1] & (hsize == STP_HSIZE_WORD);
    assign dec_addr = haddr[STP_DEC_W-1:0];
    assign wr_control = wr_pend & (wr_addr == STP_REG_CONTROL);
    assign wr_irq_status = wr_pend & (wr_addr == STP_REG_IRQ_STATUS);
    assign wr_irq_mask = wr_pend & (wr_addr == STP_REG_IRQ_MASK);

    assign status_word = {
        21'h0, seq_state, s_sysrst, s_en, fault_latched, position
    };
    assign rd_value =
        (dec_addr == STP_REG_CONTROL) ? {31'h0, drive_allow} :
        (dec_addr == STP_REG_STATUS) ? status_word :
        (dec_addr == STP_REG_IRQ_STATUS) ? {29'h0, irq_status} :
        (dec_addr == STP_REG_IRQ_MASK) ? {29'h0, irq_mask} :
        (dec_addr == STP_REG_STEP_COUNT) ?
            STP_DATA_W'(step_count) : 32'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend <= bus_take & hwrite;
            wr_addr <= dec_addr;
            hrdata <= (bus_take & ~hwrite) ? rd_value : 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drive_allow <= STP_CTRL_ALLOW_RESET;
        end else if (wr_control) begin
            drive_allow <= hwdata[STP_CTRL_ALLOW];
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    assign irq_events[STP_IRQ_STEP] = step_take;
    assign irq_events[STP_IRQ_FAULT] = |fault_new;
    assign irq_events[STP_IRQ_RESET] = (seq_state == SEQ_RESET) & s_sysrst;
    assign irq_clear = wr_irq_status ? hwdata[STP_IRQ_W-1:0] : '0;

    stp_sticky #(
        .W(STP_IRQ_W),
        .MASK_RESET(STP_IRQ_MASK_RESET)
    ) u_irq (
        .hclk(hclk),
        .hresetn(hresetn),
        .event_set(irq_events),
        .clear_ones(irq_clear),
        .mask_we(wr_irq_mask),
        .mask_wdata(hwdata[STP_IRQ_W-1:0]),
        .status(irq_status),
        .mask(irq_mask),
        .irq(irq)
    );

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_full_step_fwd: assert property (@(posedge hclk) disable iff (!hresetn)
        (step_take && !sel_half && !position[0] && !sel_dir && s_sysrst)
        |=> position == 3'($past(position) + 3'h2))
        else $error("two-phase forward step did not advance by two");

    a_half_step_fwd: assert property (@(posedge hclk) disable iff (!hresetn)
        (step_take && sel_half && !sel_dir && s_sysrst)
        |=> position == 3'($past(position) + 3'h1))
        else $error("half-step forward did not advance by one");

    a_rise_only: assert property (@(posedge hclk) disable iff (!hresetn)
        (clk_fall && sel_rise_only && s_sysrst) |=> $stable(position))
        else $error("falling edge moved position in rising-only mode");

    a_both_edges: assert property (@(posedge hclk) disable iff (!hresetn)
        (clk_fall && !sel_rise_only && seq_state == SEQ_RUN &&
         s_sysrst && s_en)
        |=> position != $past(position))
        else $error("falling edge ignored in dual-edge mode");

    a_step_once: assert property (@(posedge hclk) disable iff (!hresetn)
        (!active_edge && s_sysrst) |=> $stable(position) && $stable(step_count))
        else $error("position moved without a step clock edge");

    a_reset_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        !s_sysrst |=> position == STP_POS_INIT && seq_state == SEQ_RESET &&
                      phase_drive == 4'h0)
        else $error("sequencer not held while system reset low");

    a_reset_init: assert property (@(posedge hclk) disable iff (!hresetn)
        (seq_state == SEQ_RESET && s_sysrst)
        |=> position == STP_POS_INIT
        ##1 (!$past(drive_on) || phase_drive == STP_INIT_PATTERN))
        else $error("initial excitation not loaded at reset release");

    a_enable_off: assert property (@(posedge hclk) disable iff (!hresetn)
        !s_en |=> phase_drive == 4'h0)
        else $error("phase drive active while enable low");

    a_resume_same: assert property (@(posedge hclk) disable iff (!hresetn)
        (seq_state == SEQ_HOLD && s_en && s_sysrst)
        |=> seq_state == SEQ_RUN && $stable(position))
        else $error("position changed across enable hold");

    a_half_step_rev: assert property (@(posedge hclk) disable iff (!hresetn)
        (step_take && sel_half && sel_dir && s_sysrst)
        |=> position == 3'($past(position) - 3'h1))
        else $error("reverse half-step did not retreat by one");

    a_fault_held: assert property (@(posedge hclk) disable iff (!hresetn)
        ((|fault_latched) && s_sysrst)
        |=> ((fault_latched & $past(fault_latched)) == $past(fault_latched))
            && !fault_flag_n)
        else $error("latched fault dropped without system reset");

    a_pair_landing: assert property (@(posedge hclk) disable iff (!hresetn)
        (step_take && !sel_half && s_sysrst) |=> !position[0])
        else $error("two-phase step left a single phase energised");

    a_no_opposing: assert property (@(posedge hclk) disable iff (!hresetn)
        !(phase_drive[0] && phase_drive[1]) &&
        !(phase_drive[2] && phase_drive[3]))
        else $error("both windings of one phase energised");

endmodule // stp_phase_sequencer

// ==== rtl/stp_pkg.sv ====
/*
 * Shared constants and types of the stepper phase sequencer: register map,
 * field positions, reset values, pin indices and the excitation table.
 * Assumes a 32-bit AHB-Lite register bus and a 25 MHz system clock.
 */
package stp_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int STP_DATA_W = 32;
    localparam int STP_HADDR_W = 32;
    localparam int STP_DEC_W = 8;
    localparam logic [2:0] STP_HSIZE_WORD = 3'h2;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] STP_REG_CONTROL = 8'h00;
    localparam logic [7:0] STP_REG_STATUS = 8'h04;
    localparam logic [7:0] STP_REG_IRQ_STATUS = 8'h08;
    localparam logic [7:0] STP_REG_IRQ_MASK = 8'h0c;
    localparam logic [7:0] STP_REG_STEP_COUNT = 8'h10;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int STP_CTRL_ALLOW = 0;
    localparam logic STP_CTRL_ALLOW_RESET = 1'b1;
    localparam int STP_STAT_POS_LSB = 0;
    localparam int STP_STAT_FAULT_LSB = 3;
    localparam int STP_STAT_EN = 6;
    localparam int STP_STAT_SYSRST = 7;
    localparam int STP_STAT_STATE_LSB = 8;
    localparam int STP_IRQ_STEP = 0;
    localparam int STP_IRQ_FAULT = 1;
    localparam int STP_IRQ_RESET = 2;
    localparam int STP_IRQ_W = 3;
    localparam logic [STP_IRQ_W-1:0] STP_IRQ_MASK_RESET = 3'h0;

    // ------------------------------------------------------------------
    // Pin indices in the synchronised input vector
    // ------------------------------------------------------------------
    localparam int STP_PIN_CLK = 0;
    localparam int STP_PIN_HALF = 1;
    localparam int STP_PIN_EDGE = 2;
    localparam int STP_PIN_DIR = 3;
    localparam int STP_PIN_SYSRST = 4;
    localparam int STP_PIN_EN = 5;
    localparam int STP_PIN_OPEN = 6;
    localparam int STP_PIN_OC = 7;
    localparam int STP_PIN_OT = 8;
    localparam int STP_PIN_W = 9;

    // ------------------------------------------------------------------
    // Faults
    // ------------------------------------------------------------------
    localparam int STP_FAULT_OPEN = 0;
    localparam int STP_FAULT_OC = 1;
    localparam int STP_FAULT_OT = 2;
    localparam logic [1:0] STP_KIND_NONE = 2'h0;
    localparam logic [1:0] STP_KIND_OPEN = 2'h1;
    localparam logic [1:0] STP_KIND_OVERCURRENT = 2'h2;
    localparam logic [1:0] STP_KIND_OVERHEAT = 2'h3;

    // ------------------------------------------------------------------
    // Excitation sequence
    // ------------------------------------------------------------------
    // Nibble n is the drive of half-step position n, bit order
    // {phase two inverse, phase two true, phase one inverse, phase one true}.
    localparam logic [31:0] STP_PATTERN_TABLE = 32'h8a264519;
    localparam logic [2:0] STP_POS_INIT = 3'h0;
    localparam logic [3:0] STP_INIT_PATTERN = STP_PATTERN_TABLE[3:0];
    localparam logic [2:0] STP_STEP_HALF = 3'h1;
    localparam logic [2:0] STP_STEP_FULL = 3'h2;

    typedef enum logic [2:0] {
        SEQ_RESET = 3'b001,
        SEQ_RUN = 3'b010,
        SEQ_HOLD = 3'b100
    } stp_seq_t;

endpackage

// ==== rtl/stp_sync.sv ====
/*
 * Two-flip-flop synchroniser for a vector of independent levels.
 * Assumes each bit is a slow level; bits are not coherent with each other.
 */
`timescale 1ns/1ps
module stp_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end

endmodule // stp_sync

// ==== rtl/stp_sticky.sv ====
/*
 * Sticky event bits, cleared by writing ones, with a mask and one level
 * interrupt. Assumes set and clear strobes are on the same clock.
 */
`timescale 1ns/1ps
module stp_sticky #(
    parameter int W = 3,
    parameter logic [W-1:0] MASK_RESET = '0
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Events and software access
    input wire logic [W-1:0] event_set,
    input wire logic [W-1:0] clear_ones,
    input wire logic mask_we,
    input wire logic [W-1:0] mask_wdata,
    // State
    output logic [W-1:0] status,
    output logic [W-1:0] mask,
    output logic irq
);

    logic [W-1:0] next_status;
    logic [W-1:0] next_mask;

    // A new event in the clearing cycle survives the clear.
    assign next_status = (status & ~clear_ones) | event_set;
    assign next_mask = mask_we ? mask_wdata : mask;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status <= '0;
            mask <= MASK_RESET;
            irq <= 1'b0;
        end else begin
            status <= next_status;
            mask <= next_mask;
            irq <= |(next_status & next_mask);
        end
    end

endmodule // stp_sticky

// ==== test/stp_host_model.sv ====
/*
 * Host model: makes the step clock, one edge per 160 ns, while run is high.
 * Assumes the bench moves mode and direction levels only while run is low.
 */
`timescale 1ns/1ps
module stp_host_model (
    // Frame request
    input wire logic run,
    // Step clock
    output logic step_clock
);
    // The clock stands still between frames, so levels may move then.
    initial begin
        step_clock = 1'b0;
        #13;
        forever begin
            #160;
            if (run) step_clock = ~step_clock;
        end
    end
endmodule // stp_host_model

// ==== test/stepper_phase_sequencer_tb_top.sv ====
/*
 * Self-checking bench of the stepper phase sequencer over AHB-Lite and pins.
 * Assumes hreadyout feeds hready and the host model makes the step clock.
 */
`timescale 1ns/1ps
module stepper_phase_sequencer_tb_top;
    import stp_pkg::*;
    logic hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, hready, run = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0] htrans = 0, fault_kind_level;
    logic [2:0] hsize = 3'h2, det = 0, pos = 0, d;
    logic [3:0] drv;
    logic step_clock, excitation_select = 0, step_edge_select = 0;
    logic rotation_direction = 0, system_reset_n = 0, enable = 1;
    logic fault_flag_n, irq;
    int error_cnt = 0, n_compared = 0, cyc = 0;
    always #20 hclk = ~hclk;
    stp_host_model host (.run(run), .step_clock(step_clock));
    stp_phase_sequencer DUT (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hreadyout(hready), .hresp(), .hrdata, .step_clock,
        .excitation_select, .step_edge_select, .rotation_direction,
        .system_reset_n, .enable, .open_detect(det[0]),
        .overcurrent_detect(det[1]), .overheat_detect(det[2]),
        .phase_one_true_drive(drv[0]), .phase_one_inverse_drive(drv[1]),
        .phase_two_true_drive(drv[2]), .phase_two_inverse_drive(drv[3]),
        .fault_flag_n, .fault_kind_level, .irq
    );
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge hclk);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    // Expected position is tracked edge by edge, as the host sees them.
    task automatic steps(input int n);
        @(posedge hclk);
        run <= 1'b1;
        repeat (n) begin
            @(step_clock);
            if (enable && system_reset_n &&
                (!step_edge_select || step_clock)) begin
                d = (excitation_select || pos[0]) ? 3'h1 : 3'h2;
                pos = rotation_direction ? pos - d : pos + d;
            end
        end
        @(posedge hclk);
        run <= 1'b0;
        repeat (8) @(posedge hclk);
    endtask
    task automatic chk_drive;
        bus(1'b0, STP_REG_STATUS, 32'h0);
        chk(32'(rd[2:0]), 32'(pos));
        chk(32'(drv), 32'(STP_PATTERN_TABLE[pos*4 +: 4]));
    endtask
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 6000) begin
            error_cnt++;
            summarize;
        end
    end
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, STP_REG_CONTROL, 32'h0);
        chk(rd, 32'h1);
        bus(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        steps(4);
        chk(32'(drv), 32'h0);
        bus(1'b0, STP_REG_STATUS, 32'h0);
        chk(32'(rd[2:0]), 32'(STP_POS_INIT));
        system_reset_n <= 1'b1;
        repeat (8) @(posedge hclk);
        chk(32'(drv), 32'h9);
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            excitation_select <= i[0];
            step_edge_select <= i[1];
            rotation_direction <= i[2];
            steps(5);
            chk_drive();
        end
        $display("mode test done");
        enable <= 1'b0;
        repeat (8) @(posedge hclk);
        chk(32'(drv), 32'h0);
        steps(3);
        enable <= 1'b1;
        repeat (8) @(posedge hclk);
        chk_drive();
        $display("enable test done");
        bus(1'b1, STP_REG_CONTROL, 32'h0);
        repeat (4) @(posedge hclk);
        chk(32'(drv), 32'h0);
        bus(1'b1, STP_REG_CONTROL, 32'h1);
        repeat (4) @(posedge hclk);
        chk_drive();
        $display("allow test done");
        // The detector drops again before the check, so only a latch holds.
        bus(1'b1, STP_REG_IRQ_MASK, 32'h2);
        for (int k = 0; k < 3; k++) begin
            bus(1'b1, STP_REG_IRQ_STATUS, 32'h7);
            repeat (2) @(posedge hclk);
            chk(32'(irq), 32'h0);
            det <= 3'(1 << k);
            repeat (6) @(posedge hclk);
            det <= 3'h0;
            repeat (6) @(posedge hclk);
            chk(32'(fault_flag_n), 32'h0);
            chk(32'(fault_kind_level), 32'(k + 1));
            chk(32'(irq), 32'h1);
            system_reset_n <= 1'b0;
            repeat (6) @(posedge hclk);
            system_reset_n <= 1'b1;
            repeat (8) @(posedge hclk);
            chk(32'(fault_flag_n), 32'h1);
            pos = 3'h0;
            chk_drive();
        end
        $display("fault test done");
        summarize();
    end
endmodule // stepper_phase_sequencer_tb_top
